// File: cspr_pkg.sv
// Package with register map, field layouts and reset values of the chip-select pin configuration block
package cspr_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_OUT_DATA = 8'h00;
    localparam logic [7:0] OFF_PIN_ASSIGN_0 = 8'h04;
    localparam logic [7:0] OFF_PIN_ASSIGN_1 = 8'h08;
    localparam logic [7:0] OFF_BOOT_BASE = 8'h0c;
    localparam logic [7:0] OFF_BOOT_OPTION = 8'h10;
    localparam logic [7:0] OFF_PORT_E_ASSIGN = 8'h14;
    localparam logic [7:0] OFF_PORT_F_ASSIGN = 8'h18;
    localparam logic [7:0] OFF_STRAP_STATUS = 8'h1c;
    localparam logic [7:0] OFF_GEN_OPT_BASE = 8'h40;

    // Counts and widths
    localparam int NUM_GEN_CS = 11;
    localparam int NUM_FIELDS = 12;
    localparam int NUM_DISCRETE = 7;
    localparam int FIRST_DISCRETE_CS = 3;
    localparam int STRAP_W = 10;
    localparam int GROUP_PINS = 3;
    localparam int FIRST_ARB_CS = 0;
    localparam int FIRST_FC_CS = 3;
    localparam int FIRST_ADDR_CS = 6;

    // Pin-assignment field codes
    localparam logic [1:0] PA_DISCRETE = 2'h0;
    localparam logic [1:0] PA_ALTERNATE = 2'h1;
    localparam logic [1:0] PA_CS_8BIT = 2'h2;
    localparam logic [1:0] PA_CS_16BIT = 2'h3;

    // Strap bit positions
    localparam int STRAP_BOOT_SIZE = 0;
    localparam int STRAP_GRP2 = 1;
    localparam int STRAP_GRP3 = 2;
    localparam int STRAP_ADDR_LO = 3;
    localparam int STRAP_ADDR_HI = 7;
    localparam int STRAP_PORT_E = 8;
    localparam int STRAP_PORT_F = 9;

    // Option field encodings
    localparam logic [1:0] BYTE_DISABLE = 2'h0;
    localparam logic [1:0] BYTE_BOTH = 2'h3;
    localparam logic [1:0] RW_READ_WRITE = 2'h3;
    localparam logic [3:0] DSACK_13_WAIT = 4'hd;
    localparam logic [1:0] SPACE_SUP_USER = 2'h3;
    localparam logic [2:0] IPL_ANY = 3'h0;
    localparam logic [2:0] BLOCK_1MBYTE = 3'h7;
    localparam logic [12:0] BOOT_BASE_RESET = 13'h0000;
    localparam logic [31:0] RESET_FETCH_ADDR = 32'h0000_0000;

    // Port reset fills
    localparam logic [7:0] PORT_ALL_ONES = 8'hff;
    localparam logic [7:0] PORT_ALL_ZEROS = 8'h00;
    localparam logic [7:0] OUT_DATA_RESET = 8'h7f;

    typedef struct packed {
        logic mode;
        logic [1:0] byte_en;
        logic [1:0] rw;
        logic strb;
        logic [3:0] dsack;
        logic [1:0] space;
        logic [2:0] ipl;
        logic avec;
    } cspr_opt_s;

    typedef struct packed {
        logic [12:0] base_addr;
        logic [2:0] block_size;
    } cspr_base_s;

    localparam cspr_opt_s BOOT_OPT_RESET = '{mode: 1'b0, byte_en: BYTE_BOTH, rw: RW_READ_WRITE, strb: 1'b0,
        dsack: DSACK_13_WAIT, space: SPACE_SUP_USER, ipl: IPL_ANY, avec: 1'b0};
    localparam cspr_opt_s GEN_OPT_RESET = '{mode: 1'b0, byte_en: BYTE_DISABLE, rw: 2'h0, strb: 1'b0,
        dsack: 4'h0, space: 2'h0, ipl: IPL_ANY, avec: 1'b0};
    localparam cspr_base_s BOOT_BASE_RESET_S = '{base_addr: BOOT_BASE_RESET, block_size: BLOCK_1MBYTE};

    typedef struct packed {
        cspr_base_s boot_base;
        cspr_opt_s boot_option;
        logic [7:0] port_e_pin_assign;
        logic [7:0] port_f_pin_assign;
    } cspr_cfg_s;

endpackage

// File: cspr_top.sv
// Chip-select pin function configuration with reset strap capture and APB register file
//
// Summary of operation
// - A chip-select pin 9..3 assigned as discrete output drives its output data bit.
// - Output data bits 6..0 drive chip-select pins 9..3; all reset to one.
// - Output data bit 7 ignores writes and always reads zero.
// - Straps are sampled on every reset of this block, not on reset instruction.
// - Data bus weakly pulled high during reset; external pull-low picks alternates.
// - Strap bit 0 low gives boot chip-select 8-bit port, else 16-bit.
// - Strap 1 low makes cs0-2 bus arbitration; strap 2 low makes cs3-5 function codes.
// - Straps 3..7 low make their address line and all lower ones address lines.
// - Boot assignment field upper bit resets one; lower bit loaded from strap 0.
// - Fields for cs10..cs0 reset low bit one, high bit from straps 7..1.
// - Boot chip-select active after reset; cs10..cs0 disabled until programmed.
// - After reset the first fetch address is zero.
// - Boot base address resets to zero, block size to one megabyte.
// - Boot byte field resets to both bytes; general option byte fields to disable.
// - Other boot options reset async, read/write, AS timing, 13 waits, any level.
// - Strap 8 low clears port E assignment to zero, else bus control.
// - Strap 9 decides whether port F comes up as interrupt inputs or I/O.
// - Strap 9 high sets port F assignment to all ones, low to all zeros.
`timescale 1ns/10ps
module cspr_top #(
    parameter int ADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [cspr_pkg::STRAP_W-1:0] strap_bus,
    output logic data_bus_pullup_en,
    output logic straps_captured,
    output logic [2*cspr_pkg::NUM_FIELDS-1:0] cs_pin_function,
    output logic [cspr_pkg::NUM_DISCRETE-1:0] chip_select_pins_9_to_3,
    output logic [cspr_pkg::NUM_DISCRETE-1:0] chip_select_pins_9_to_3_discrete,
    output logic boot_port_16bit,
    output logic [cspr_pkg::NUM_FIELDS-1:0] cs_select_enabled,
    output logic [31:0] reset_fetch_addr,
    output cspr_pkg::cspr_cfg_s cfg
);

    // Strap synchroniser, free of reset so it tracks the pins during reset
    logic [cspr_pkg::STRAP_W-1:0] strap_meta;
    logic [cspr_pkg::STRAP_W-1:0] strap_sync;

    always_ff @(posedge pclk) begin
        strap_meta <= strap_bus;
        strap_sync <= strap_meta;
    end

    // Register state
    logic captured;
    logic [cspr_pkg::NUM_DISCRETE-1:0] discrete_out_bits;
    logic [2*cspr_pkg::NUM_FIELDS-1:0] pin_assign;
    cspr_pkg::cspr_base_s boot_cs_base;
    cspr_pkg::cspr_opt_s boot_cs_option;
    cspr_pkg::cspr_opt_s general_cs_options [cspr_pkg::NUM_GEN_CS];
    logic [7:0] port_e_pin_assign;
    logic [7:0] port_f_pin_assign;
    logic [cspr_pkg::STRAP_W-1:0] strap_seen;

    // Low bit index of the assignment field of a general chip-select
    function automatic int field_lo(
        input int cs
    );
        return 2 * (cs + 1);
    endfunction

    // Pin-assignment image from straps
    function automatic logic [2*cspr_pkg::NUM_FIELDS-1:0] strap_assign(
        input logic [cspr_pkg::STRAP_W-1:0] s
    );
        logic [2*cspr_pkg::NUM_FIELDS-1:0] f;
        logic addr_all_high;
        f = '1;
        addr_all_high = 1'b1;
        // Boot port size
        f[0] = s[cspr_pkg::STRAP_BOOT_SIZE];
        // Arbitration and function-code groups
        for (int i = 0; i < cspr_pkg::GROUP_PINS; i++) begin
            f[field_lo(cspr_pkg::FIRST_ARB_CS + i) + 1] = s[cspr_pkg::STRAP_GRP2];
            f[field_lo(cspr_pkg::FIRST_FC_CS + i) + 1] = s[cspr_pkg::STRAP_GRP3];
        end
        // Address group, top line first so a low strap covers all lines below it
        for (int k = cspr_pkg::STRAP_ADDR_HI - cspr_pkg::STRAP_ADDR_LO; k >= 0; k--) begin
            addr_all_high = addr_all_high & s[cspr_pkg::STRAP_ADDR_LO + k];
            f[field_lo(cspr_pkg::FIRST_ADDR_CS + k) + 1] = addr_all_high;
        end
        return f;
    endfunction

    // Byte-lane merge of a write into an old word
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0] st
    );
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                r[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return r;
    endfunction

    // Address decode
    wire logic setup_phase = psel && !penable;
    wire logic access_phase = psel && penable;
    wire logic [7:0] word_addr = {paddr[7:2], 2'b00};
    wire logic aligned = (paddr[1:0] == 2'b00);
    wire logic hit_out = aligned && (word_addr == cspr_pkg::OFF_OUT_DATA);
    wire logic hit_pa0 = aligned && (word_addr == cspr_pkg::OFF_PIN_ASSIGN_0);
    wire logic hit_pa1 = aligned && (word_addr == cspr_pkg::OFF_PIN_ASSIGN_1);
    wire logic hit_base = aligned && (word_addr == cspr_pkg::OFF_BOOT_BASE);
    wire logic hit_bopt = aligned && (word_addr == cspr_pkg::OFF_BOOT_OPTION);
    wire logic hit_pe = aligned && (word_addr == cspr_pkg::OFF_PORT_E_ASSIGN);
    wire logic hit_pf = aligned && (word_addr == cspr_pkg::OFF_PORT_F_ASSIGN);
    wire logic hit_stat = aligned && (word_addr == cspr_pkg::OFF_STRAP_STATUS);
    wire logic [7:0] gen_rel = word_addr - cspr_pkg::OFF_GEN_OPT_BASE;
    wire logic [5:0] gen_idx = gen_rel[7:2];
    wire logic hit_gen = aligned && (word_addr >= cspr_pkg::OFF_GEN_OPT_BASE)
        && (gen_idx < 6'(cspr_pkg::NUM_GEN_CS));
    wire logic [3:0] gen_sel = hit_gen ? gen_idx[3:0] : 4'h0;
    wire logic hit_any = hit_out || hit_pa0 || hit_pa1 || hit_base || hit_bopt || hit_pe || hit_pf
        || hit_stat || hit_gen;
    wire logic bad_write = pwrite && hit_stat;
    wire logic wr_en = access_phase && pwrite && hit_any && !bad_write;

    // Read mux
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        if (hit_out) begin
            rd_mux = {25'h0, discrete_out_bits};
        end else if (hit_pa0) begin
            rd_mux = {18'h0, pin_assign[13:0]};
        end else if (hit_pa1) begin
            rd_mux = {22'h0, pin_assign[23:14]};
        end else if (hit_base) begin
            rd_mux = {16'h0, boot_cs_base};
        end else if (hit_bopt) begin
            rd_mux = {16'h0, boot_cs_option};
        end else if (hit_pe) begin
            rd_mux = {24'h0, port_e_pin_assign};
        end else if (hit_pf) begin
            rd_mux = {24'h0, port_f_pin_assign};
        end else if (hit_stat) begin
            rd_mux = {21'h0, captured, strap_seen};
        end else if (hit_gen) begin
            rd_mux = {16'h0, general_cs_options[gen_sel]};
        end
    end

    // Write data images
    wire logic [31:0] w_out = lane_merge({25'h0, discrete_out_bits}, pwdata, pstrb);
    wire logic [31:0] w_pa0 = lane_merge({18'h0, pin_assign[13:0]}, pwdata, pstrb);
    wire logic [31:0] w_pa1 = lane_merge({22'h0, pin_assign[23:14]}, pwdata, pstrb);
    wire logic [31:0] w_base = lane_merge({16'h0, boot_cs_base}, pwdata, pstrb);
    wire logic [31:0] w_bopt = lane_merge({16'h0, boot_cs_option}, pwdata, pstrb);
    wire logic [31:0] w_gen = lane_merge({16'h0, general_cs_options[gen_sel]}, pwdata, pstrb);
    wire logic [31:0] w_pe = lane_merge({24'h0, port_e_pin_assign}, pwdata, pstrb);
    wire logic [31:0] w_pf = lane_merge({24'h0, port_f_pin_assign}, pwdata, pstrb);
    wire logic [2*cspr_pkg::NUM_FIELDS-1:0] strap_fields = strap_assign(strap_sync);

    // APB answer registered in setup phase, one access cycle
    logic [31:0] rd_q;
    logic err_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_q <= 32'h0;
            err_q <= 1'b0;
        end else if (setup_phase) begin
            rd_q <= pwrite ? 32'h0 : rd_mux;
            err_q <= !hit_any || bad_write;
        end
    end

    assign prdata = rd_q;
    assign pready = 1'b1;
    assign pslverr = access_phase && err_q;

    // Strap capture at the first edge after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            captured <= 1'b0;
            strap_seen <= '1;
        end else if (!captured) begin
            captured <= 1'b1;
            strap_seen <= strap_sync;
        end
    end

    // Discrete output data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            discrete_out_bits <= cspr_pkg::OUT_DATA_RESET[cspr_pkg::NUM_DISCRETE-1:0];
        end else if (wr_en && hit_out) begin
            discrete_out_bits <= w_out[cspr_pkg::NUM_DISCRETE-1:0];
        end
    end

    // Chip-select pin assignment
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_assign <= '1;
        end else if (!captured) begin
            pin_assign <= strap_fields;
        end else if (wr_en && hit_pa0) begin
            pin_assign[13:0] <= w_pa0[13:0];
        end else if (wr_en && hit_pa1) begin
            pin_assign[23:14] <= w_pa1[9:0];
        end
    end

    // Boot base
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_cs_base <= cspr_pkg::BOOT_BASE_RESET_S;
        end else if (wr_en && hit_base) begin
            boot_cs_base <= w_base[15:0];
        end
    end

    // Boot option
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_cs_option <= cspr_pkg::BOOT_OPT_RESET;
        end else if (wr_en && hit_bopt) begin
            boot_cs_option <= w_bopt[15:0];
        end
    end

    // General option registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < cspr_pkg::NUM_GEN_CS; i++) begin
                general_cs_options[i] <= cspr_pkg::GEN_OPT_RESET;
            end
        end else if (wr_en && hit_gen) begin
            general_cs_options[gen_sel] <= w_gen[15:0];
        end
    end

    // Port E assignment
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_e_pin_assign <= cspr_pkg::PORT_ALL_ONES;
        end else if (!captured) begin
            port_e_pin_assign <= strap_sync[cspr_pkg::STRAP_PORT_E] ?
                cspr_pkg::PORT_ALL_ONES : cspr_pkg::PORT_ALL_ZEROS;
        end else if (wr_en && hit_pe) begin
            port_e_pin_assign <= w_pe[7:0];
        end
    end

    // Port F assignment
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_f_pin_assign <= cspr_pkg::PORT_ALL_ONES;
        end else if (!captured) begin
            port_f_pin_assign <= strap_sync[cspr_pkg::STRAP_PORT_F] ?
                cspr_pkg::PORT_ALL_ONES : cspr_pkg::PORT_ALL_ZEROS;
        end else if (wr_en && hit_pf) begin
            port_f_pin_assign <= w_pf[7:0];
        end
    end

    // Pin drive for discrete chip-select outputs
    logic [cspr_pkg::NUM_DISCRETE-1:0] disc_mode;
    always_comb begin
        for (int p = 0; p < cspr_pkg::NUM_DISCRETE; p++) begin
            disc_mode[p] = pin_assign[field_lo(p + cspr_pkg::FIRST_DISCRETE_CS) +: 2] == cspr_pkg::PA_DISCRETE;
        end
    end

    assign chip_select_pins_9_to_3_discrete = disc_mode;
    assign chip_select_pins_9_to_3 = discrete_out_bits | ~disc_mode;

    // Chip-select enables from byte fields
    always_comb begin
        cs_select_enabled[0] = boot_cs_option.byte_en != cspr_pkg::BYTE_DISABLE;
        for (int c = 0; c < cspr_pkg::NUM_GEN_CS; c++) begin
            cs_select_enabled[c+1] = general_cs_options[c].byte_en != cspr_pkg::BYTE_DISABLE;
        end
    end

    // Configuration outputs
    assign cs_pin_function = pin_assign;
    assign boot_port_16bit = pin_assign[1:0] == cspr_pkg::PA_CS_16BIT;
    assign data_bus_pullup_en = !captured;
    assign straps_captured = captured;
    assign reset_fetch_addr = cspr_pkg::RESET_FETCH_ADDR;
    assign cfg.boot_base = boot_cs_base;
    assign cfg.boot_option = boot_cs_option;
    assign cfg.port_e_pin_assign = port_e_pin_assign;
    assign cfg.port_f_pin_assign = port_f_pin_assign;

endmodule

// File: cspr_dummy_unused.sv
// Spare design file, holds no logic; the block lives entirely in its top module

// File: cspr_checker.sv
// Assertion checker for the chip-select pin configuration block
`timescale 1ns/10ps
module cspr_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic data_bus_pullup_en,
    input wire logic straps_captured,
    input wire logic [23:0] cs_pin_function,
    input wire logic [6:0] chip_select_pins_9_to_3,
    input wire logic [6:0] chip_select_pins_9_to_3_discrete,
    input wire logic boot_port_16bit,
    input wire logic [11:0] cs_select_enabled,
    input wire logic [31:0] reset_fetch_addr,
    input wire cspr_pkg::cspr_cfg_s cfg
);
    logic [6:0] fdisc;
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            fdisc[i] = cs_pin_function[2*i+8 +: 2] == 2'h0;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_pin_lvl;
        (chip_select_pins_9_to_3 | chip_select_pins_9_to_3_discrete) == 7'h7f;
    endproperty
    a_pin_lvl: assert property (p_pin_lvl) else $error("non-discrete pin not high");
    property p_disc;
        chip_select_pins_9_to_3_discrete == fdisc;
    endproperty
    a_disc: assert property (p_disc) else $error("discrete flags differ from fields");
    property p_boot16;
        boot_port_16bit == (cs_pin_function[1:0] == 2'h3);
    endproperty
    a_boot16: assert property (p_boot16) else $error("boot port size flag wrong");
    property p_boot_en;
        cs_select_enabled[0] == (cfg.boot_option.byte_en != 2'h0);
    endproperty
    a_boot_en: assert property (p_boot_en) else $error("boot enable wrong");
    property p_fetch;
        reset_fetch_addr == 32'h0;
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch address not zero");
    property p_cap;
        $rose(presetn) |=> straps_captured && !data_bus_pullup_en;
    endproperty
    a_cap: assert property (p_cap) else $error("capture missing after release");
    property p_keep;
        straps_captured |=> straps_captured;
    endproperty
    a_keep: assert property (p_keep) else $error("capture flag dropped");
    property p_hold;
        straps_captured && !(psel && penable && pwrite) |=> $stable(cs_pin_function) && $stable(cfg);
    endproperty
    a_hold: assert property (p_hold) else $error("assignment changed without write");
    property p_boot_hi;
        $rose(straps_captured) |-> cs_pin_function[1];
    endproperty
    a_boot_hi: assert property (p_boot_hi) else $error("boot field upper bit low");
    property p_low1;
        $rose(straps_captured) |-> (cs_pin_function[23:2] & 22'h155555) == 22'h155555;
    endproperty
    a_low1: assert property (p_low1) else $error("field low bit not one");
    property p_ports;
        $rose(straps_captured) |-> cfg.port_e_pin_assign inside {8'h00, 8'hff}
            && cfg.port_f_pin_assign inside {8'h00, 8'hff};
    endproperty
    a_ports: assert property (p_ports) else $error("port assignment not uniform");
endmodule

bind cspr_top cspr_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .data_bus_pullup_en(data_bus_pullup_en), .straps_captured(straps_captured),
    .cs_pin_function(cs_pin_function), .chip_select_pins_9_to_3(chip_select_pins_9_to_3),
    .chip_select_pins_9_to_3_discrete(chip_select_pins_9_to_3_discrete), .boot_port_16bit(boot_port_16bit),
    .cs_select_enabled(cs_select_enabled), .reset_fetch_addr(reset_fetch_addr), .cfg(cfg));

// File: cspr_strap_pulls.sv
// External strap pulls on the data bus
`timescale 1ns/10ps
module cspr_strap_pulls (
    input wire logic pclk,
    input wire logic pullup_en,
    input wire logic [9:0] pull_low,
    output logic [9:0] strap_bus
);
    logic flt = 1'b0;
    always @(posedge pclk) begin
        flt <= ~flt;
    end
    // Pulled bits low, open bits weakly high or floating
    always_comb begin
        for (int i = 0; i < 10; i++) begin
            strap_bus[i] = pull_low[i] ? 1'b0 : (pullup_en ? 1'b1 : flt);
        end
    end
endmodule

// File: cspr_top_tb.sv
// Self-checking testbench for the chip-select pin configuration block
`timescale 1ns/10ps
module cspr_top_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [9:0] pull_low = 10'h000;
    logic [31:0] prdata, fetch, rd;
    logic pready, pslverr, pu, cap, b16, er;
    logic [9:0] strap;
    logic [23:0] func;
    logic [6:0] pins, disc;
    logic [11:0] en;
    cspr_pkg::cspr_cfg_s cfg;
    int fail_count = 0;
    int n_tests = 0;
    always #12.5 pclk = ~pclk;
    cspr_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .strap_bus(strap), .data_bus_pullup_en(pu), .straps_captured(cap), .cs_pin_function(func),
        .chip_select_pins_9_to_3(pins), .chip_select_pins_9_to_3_discrete(disc), .boot_port_16bit(b16),
        .cs_select_enabled(en), .reset_fetch_addr(fetch), .cfg(cfg));
    cspr_strap_pulls pulls (.pclk(pclk), .pullup_en(pu), .pull_low(pull_low), .strap_bus(strap));
    task automatic end_of_test;
        if (fail_count == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
        chk("rd_err", 0, er);
    endtask
    function automatic logic [23:0] exp_func(input logic [9:0] s);
        logic [23:0] f;
        f[1:0] = {1'b1, s[0]};
        for (int c = 0; c < 11; c++) begin
            f[2*c+3] = c < 3 ? s[1] : c < 6 ? s[2] : &(s[7:0] | ~(8'hff << (c - 3)));
            f[2*c+2] = 1'b1;
        end
        return f;
    endfunction
    task automatic t_reset(input logic [9:0] m);
        logic [9:0] s;
        logic [23:0] f;
        s = ~m;
        f = exp_func(s);
        @(posedge pclk);
        pull_low <= m;
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        chk("pullup_rst", 1, pu);
        chk("cap_rst", 0, cap);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        #1;
        chk("cap", 1, cap);
        chk("pullup", 0, pu);
        chk("func", f, func);
        chk("b16", s[0], b16);
        chk("port_e", {8{s[8]}}, cfg.port_e_pin_assign);
        chk("port_f", {8{s[9]}}, cfg.port_f_pin_assign);
        rchk("status", 8'h1c, {21'h0, 1'b1, s});
        pull_low <= ~m;
        repeat (8) @(posedge pclk);
        #1;
        chk("func_hold", f, func);
    endtask
    task automatic t_regs;
        rchk("out_data", 8'h00, 32'h7f);
        rchk("pin_as0", 8'h04, 32'h3fff);
        rchk("pin_as1", 8'h08, 32'h3ff);
        rchk("boot_base", 8'h0c, 32'h7);
        rchk("boot_opt", 8'h10, 32'h7b70);
        for (int i = 0; i < 11; i++) begin
            rchk("gen_opt", 8'h40 + 8'(4 * i), 32'h0);
        end
        chk("enabled", 12'h001, en);
        chk("cfg_base", 32'h7, cfg.boot_base);
        chk("cfg_opt", 32'h7b70, cfg.boot_option);
        chk("fetch", 0, fetch);
    endtask
    task automatic t_disc;
        apb(1'b1, 8'h04, 32'hff);
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b1, 8'h00, 32'hd5);
        #1;
        chk("disc", 7'h7f, disc);
        chk("pins", 7'h55, pins);
        rchk("out_rd", 8'h00, 32'h55);
        apb(1'b1, 8'h00, 32'h2a);
        apb(1'b1, 8'h08, 32'h3ff);
        #1;
        chk("pins2", 7'h7a, pins);
        chk("disc2", 7'h07, disc);
        apb(1'b1, 8'h40, 32'h2000);
        #1;
        chk("en_gen", 12'h003, en);
    endtask
    task automatic t_err;
        apb(1'b0, 8'h20, 32'h0);
        chk("err_unmapped", 1, er);
        apb(1'b0, 8'h02, 32'h0);
        chk("err_unaligned", 1, er);
        apb(1'b1, 8'h1c, 32'h0);
        chk("err_status_wr", 1, er);
        rchk("status_kept", 8'h1c, 32'h7ff);
    endtask
    initial begin
        t_reset(10'h3ff);
        t_reset(10'h020);
        t_reset(10'h106);
        t_reset(10'h209);
        t_reset(10'h000);
        t_regs();
        t_disc();
        t_err();
        end_of_test();
    end
    initial begin
        repeat (3000) @(posedge pclk);
        fail_count++;
        end_of_test();
    end
endmodule
